// ===== luma_gamma_pkg.sv
// Shared constants and types for the luma gamma and brightness unit.
package luma_gamma_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int GAMMA_REG_COUNT = 14;
   localparam int CURVE_POINTS = 7;
   localparam logic [5:0] SUB_GAMMA_FIRST = 6'h26;
   localparam logic [5:0] SUB_GAMMA_LAST = 6'h33;
   localparam logic [5:0] SUB_BRIGHTNESS = 6'h34;
   localparam logic [5:0] SUB_CLOCK_CTRL = 6'h35;
   localparam int CLK_PIN_DRIVE_BIT = 1;
   localparam logic [7:0] CLOCK_CTRL_RESET = 8'h70;
   localparam logic [7:0] BRIGHTNESS_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // -----------------------------------------------------------------
   // Gamma curve geometry
   // -----------------------------------------------------------------
   localparam logic [7:0] LOW_FIXED_CODE = 8'h10;
   localparam logic [7:0] HIGH_FIXED_CODE = 8'hf0;
   localparam logic [7:0] FIRST_BREAKPOINT = 8'h20;
   localparam logic [2:0] FIRST_SEGMENT = 3'h0;
   localparam logic [2:0] LAST_SEGMENT = 3'h7;
   localparam logic [2:0] EDGE_SEG_SHIFT = 3'h4;
   localparam logic [2:0] INNER_SEG_SHIFT = 3'h5;
   typedef logic [CURVE_POINTS-1:0][7:0] curve_t;
   typedef logic [GAMMA_REG_COUNT-1:0][7:0] gamma_bank_t;
   // Identity curve: 32, 64, ... 224 at breakpoints 32 ... 224.
   localparam curve_t GAMMA_RESET = {8'he0, 8'hc0, 8'ha0, 8'h80, 8'h60, 8'h40, 8'h20};

   // -----------------------------------------------------------------
   // Brightness divider and serial link
   // -----------------------------------------------------------------
   localparam logic [3:0] DIV_STEPS = 4'h8;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [3:0] {
      LK_IDLE = 4'h0,
      LK_ADDR = 4'h1,
      LK_ADDR_ACK = 4'h2,
      LK_SUB = 4'h3,
      LK_SUB_ACK = 4'h4,
      LK_WRITE = 4'h5,
      LK_WRITE_ACK = 4'h6,
      LK_READ = 4'h7,
      LK_READ_ACK = 4'h8
   } link_state_t;
endpackage

// ===== gamma_pwl_map.sv
// Piecewise-linear gamma mapping of one luma sample per cycle.
`timescale 1ns/1ps
module gamma_pwl_map
   import luma_gamma_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_enable,
   input wire logic i_valid,
   input wire logic [7:0] i_luma,
   input wire curve_t i_points,
   output logic o_valid,
   output logic [7:0] o_luma
);
   typedef struct packed {
      logic valid;
      logic [7:0] luma;
   } map_state_t;

   map_state_t s_q;
   map_state_t s_d;
   logic [7:0] pt0;
   logic [7:0] seg_lo;
   logic [7:0] seg_hi;

   // ---------------------------------------------------------------
   // Interpolation
   // ---------------------------------------------------------------
   always_comb begin
      logic [2:0] seg;
      logic [2:0] lo_idx;
      logic [7:0] xa;
      logic [7:0] ya;
      logic [7:0] yb;
      logic [5:0] off;
      logic [2:0] shift;
      logic signed [8:0] dy;
      logic signed [15:0] prod;
      logic signed [15:0] step;
      logic signed [16:0] sum;
      s_d = s_q;
      seg = i_luma[7:5];
      lo_idx = (seg == FIRST_SEGMENT) ? FIRST_SEGMENT : seg - 3'h1;
      ya = (seg == FIRST_SEGMENT) ? LOW_FIXED_CODE : i_points[lo_idx]; // RULE6
      yb = (seg == LAST_SEGMENT) ? HIGH_FIXED_CODE : i_points[seg]; // RULE4
      xa = (seg == FIRST_SEGMENT) ? LOW_FIXED_CODE : {seg, 5'h00};
      off = 6'(i_luma - xa);
      shift = (seg == FIRST_SEGMENT || seg == LAST_SEGMENT) ? EDGE_SEG_SHIFT : INNER_SEG_SHIFT;
      dy = $signed({1'b0, yb}) - $signed({1'b0, ya});
      prod = dy * $signed({1'b0, off}); // RULE5
      step = prod >>> shift;
      sum = $signed({9'h000, ya}) + 17'(step);
      seg_lo = (ya < yb) ? ya : yb;
      seg_hi = (ya < yb) ? yb : ya;
      pt0 = i_points[0];
      s_d.valid = i_valid;
      if (!i_enable || i_luma < LOW_FIXED_CODE || i_luma > HIGH_FIXED_CODE) begin
         s_d.luma = i_luma; // RULE16
      end else if (sum < 0) begin
         s_d.luma = 8'h00;
      end else if (sum > 17'sh000ff) begin
         s_d.luma = 8'hff;
      end else begin
         s_d.luma = sum[7:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_valid = s_q.valid;
   assign o_luma = s_q.luma;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   chk_low_passthru: assert property ( // RULE16
      i_ce && i_valid && i_luma < LOW_FIXED_CODE |=> o_luma == $past(i_luma))
      else $error("Luma below the low fixed code was altered.");
   chk_fixed_top: assert property ( // RULE6
      i_ce && i_enable && i_luma == HIGH_FIXED_CODE |=> o_luma == HIGH_FIXED_CODE)
      else $error("Fixed top point did not map to itself.");
   chk_first_break: assert property ( // RULE4
      i_ce && i_enable && i_luma == FIRST_BREAKPOINT |=> o_luma == $past(pt0))
      else $error("First breakpoint output does not follow its register.");
   chk_interp_bound: assert property ( // RULE5
      i_ce && i_enable && i_luma >= LOW_FIXED_CODE && i_luma <= HIGH_FIXED_CODE
      |=> o_luma >= $past(seg_lo) && o_luma <= $past(seg_hi))
      else $error("Interpolated output lies outside its segment.");
endmodule

// ===== field_brightness_meter.sv
// Per-field average luma over active video, divided serially at field end.
`timescale 1ns/1ps
module field_brightness_meter
   import luma_gamma_pkg::*;
#(
   parameter int CNT_W = 20
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_valid,
   input wire logic i_active,
   input wire logic i_vsync_n,
   input wire logic [7:0] i_luma,
   output logic [7:0] o_avg_brightness
);
   localparam int SUM_W = CNT_W + 8;

   if (CNT_W < 8 || CNT_W > 24) begin : g_bad_width
      $error("CNT_W must lie between 8 and 24.");
   end

   typedef struct packed {
      logic vsync_prev;
      logic [SUM_W-1:0] sum;
      logic [CNT_W-1:0] cnt;
      logic [SUM_W-1:0] rem;
      logic [CNT_W-1:0] den;
      logic [7:0] quo;
      logic [3:0] step;
      logic busy;
      logic [7:0] avg;
   } meter_state_t;

   meter_state_t s_q;
   meter_state_t s_d;
   logic vs_fall;

   // ---------------------------------------------------------------
   // Accumulate and divide
   // ---------------------------------------------------------------
   always_comb begin
      logic [SUM_W-1:0] trial;
      logic [7:0] q;
      logic [2:0] bit_idx;
      s_d = s_q;
      trial = '0;
      q = s_q.quo;
      bit_idx = 3'(s_q.step - 4'h1);
      vs_fall = s_q.vsync_prev && !i_vsync_n;
      s_d.vsync_prev = i_vsync_n;
      if (s_q.busy) begin
         trial = SUM_W'(s_q.den) << bit_idx;
         if (s_q.rem >= trial) begin
            s_d.rem = s_q.rem - trial;
            q[bit_idx] = 1'b1;
         end
         s_d.quo = q;
         s_d.step = s_q.step - 4'h1;
         if (s_q.step == 4'h1) begin
            s_d.busy = 1'b0;
            s_d.avg = (s_q.den == '0) ? BRIGHTNESS_RESET : q; // RULE10
         end
      end
      // The sample in the edge cycle is dropped; it falls in blanking anyway.
      if (vs_fall) begin
         s_d.rem = s_q.sum;
         s_d.den = s_q.cnt;
         s_d.quo = 8'h00;
         s_d.step = DIV_STEPS;
         s_d.busy = 1'b1;
         s_d.sum = '0;
         s_d.cnt = '0;
      end else if (i_valid && i_active && !(&s_q.cnt)) begin // RULE9
         s_d.sum = s_q.sum + SUM_W'(i_luma);
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
         s_q.vsync_prev <= 1'b1;
         s_q.avg <= BRIGHTNESS_RESET;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_avg_brightness = s_q.avg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   chk_blank_hold: assert property ( // RULE9
      !vs_fall && !(i_valid && i_active) |=> $stable(s_q.sum) && $stable(s_q.cnt))
      else $error("Accumulator moved outside active video.");
   chk_avg_moment: assert property ( // RULE10
      $changed(o_avg_brightness) |-> $past(s_q.busy) && $past(s_q.step) == 4'h1)
      else $error("Readback changed outside the field update.");
   chk_divide_len: assert property ( // RULE10
      (vs_fall && i_ce) ##1 (i_ce [*8]) |=> !s_q.busy)
      else $error("Field average not ready eight cycles after sync fall.");
endmodule

// ===== luma_gamma_brightness_unit.sv
// Top of the luma gamma, brightness readback and clock output unit.
//
// Function
// [RULE1] Fourteen byte-wide gamma registers at consecutive subaddresses hold curves A and B.
// [RULE2] Gamma applies to luma only; chroma passes through unmodified.
// [RULE3] Exactly one stored curve maps luma at any time, never a mix.
// [RULE4] Programmable outputs sit at inputs 32, 64, 96, 128, 160, 192, 224.
// [RULE5] Between breakpoints the output is linearly interpolated.
// [RULE6] Outputs at inputs 0, 16, 240 and 255 are fixed, not writable.
// [RULE7] The host keeps every programmed breakpoint output within 16 to 240.
// [RULE8] A read-only byte register reports average field brightness.
// [RULE9] Brightness accumulates luma inside active video only.
// [RULE10] The brightness readback updates once per field at vertical sync fall.
// [RULE11] Setting the pin drive bit drives the PLL clock onto the clock pin.
// [RULE12] Clock drive works only with PLL enabled and oversampling enabled.
// [RULE13] Host writes zero to clock register bits 0, 2, 3 and 7.
// [RULE14] Host writes ones to clock register bits 4 to 6.
// [RULE15] First seven gamma registers form curve A ascending, next seven curve B.
// [RULE16] Fixed points map to themselves; inputs below 16 or above 240 pass unchanged.
`timescale 1ns/1ps
module luma_gamma_brightness_unit
   import luma_gamma_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2c,
   parameter int CNT_W = 20
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire logic i_pix_valid,
   input wire logic i_active_video,
   input wire logic i_vsync_n,
   input wire logic [7:0] i_luma,
   input wire logic [7:0] i_chroma,
   input wire logic i_gamma_enable,
   input wire logic i_curve_b_select,
   input wire logic i_pll_disable_bit,
   input wire logic i_oversampling_enable_bit,
   input wire logic i_pll_clk,
   output logic o_pix_valid,
   output logic [7:0] o_luma,
   output logic [7:0] o_chroma,
   output logic o_pll_clock_output_pin
);
   typedef struct packed {
      logic scl_meta;
      logic scl_s;
      logic scl_prev;
      logic sda_meta;
      logic sda_s;
      logic sda_prev;
      link_state_t fsm;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic [5:0] subaddr;
      logic drive;
      gamma_bank_t gamma;
      logic [7:0] clkctrl;
      logic pll_clock_output_pin_en;
      logic [7:0] chroma;
   } unit_state_t;

   unit_state_t s_q;
   unit_state_t s_d;
   curve_t active_curve;
   logic [7:0] avg_brightness;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic wr_fire;
   logic gamma_hit;
   logic [3:0] gidx;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   function automatic logic is_gamma(input logic [5:0] sub);
      return sub >= SUB_GAMMA_FIRST && sub <= SUB_GAMMA_LAST;
   endfunction

   function automatic logic [3:0] gamma_index(input logic [5:0] sub);
      logic [5:0] rel;
      rel = sub - SUB_GAMMA_FIRST;
      return rel[3:0];
   endfunction

   function automatic logic [7:0] rd_byte(input logic [5:0] sub, input gamma_bank_t regs,
                                          input logic [7:0] avg, input logic [7:0] ctrl);
      logic [7:0] r;
      r = READ_UNMAPPED;
      if (is_gamma(sub)) begin
         r = regs[gamma_index(sub)];
      end else if (sub == SUB_BRIGHTNESS) begin
         r = avg;
      end else if (sub == SUB_CLOCK_CTRL) begin
         r = ctrl;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Curve selection
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < CURVE_POINTS; i++) begin
         active_curve[i] = i_curve_b_select ? s_q.gamma[i + CURVE_POINTS] : s_q.gamma[i]; // RULE3
      end
   end

   gamma_pwl_map u_map (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_enable(i_gamma_enable),
      .i_valid(i_pix_valid),
      .i_luma(i_luma),
      .i_points(active_curve),
      .o_valid(o_pix_valid),
      .o_luma(o_luma)
   );

   field_brightness_meter #(
      .CNT_W(CNT_W)
   ) u_meter (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_valid(i_pix_valid),
      .i_active(i_active_video),
      .i_vsync_n(i_vsync_n),
      .i_luma(i_luma),
      .o_avg_brightness(avg_brightness)
   );

   // ---------------------------------------------------------------
   // Serial register port
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0] rd;
      s_d = s_q;
      rd = READ_UNMAPPED;
      scl_rise = s_q.scl_s && !s_q.scl_prev;
      scl_fall = !s_q.scl_s && s_q.scl_prev;
      start_seen = s_q.scl_s && s_q.scl_prev && s_q.sda_prev && !s_q.sda_s;
      stop_seen = s_q.scl_s && s_q.scl_prev && !s_q.sda_prev && s_q.sda_s;
      wr_fire = scl_fall && s_q.fsm == LK_WRITE && s_q.bitcnt == BITS_PER_BYTE;
      gamma_hit = is_gamma(s_q.subaddr);
      gidx = gamma_index(s_q.subaddr);
      s_d.scl_meta = i_scl;
      s_d.scl_s = s_q.scl_meta;
      s_d.scl_prev = s_q.scl_s;
      s_d.sda_meta = i_sda;
      s_d.sda_s = s_q.sda_meta;
      s_d.sda_prev = s_q.sda_s;
      s_d.chroma = i_chroma; // RULE2
      s_d.pll_clock_output_pin_en = s_q.clkctrl[CLK_PIN_DRIVE_BIT] && !i_pll_disable_bit
                      && i_oversampling_enable_bit; // RULE12
      if (start_seen) begin
         s_d.fsm = LK_ADDR;
         s_d.bitcnt = 4'h0;
         s_d.drive = 1'b0;
      end else if (stop_seen) begin
         s_d.fsm = LK_IDLE;
         s_d.drive = 1'b0;
      end else if (scl_rise) begin
         unique case (s_q.fsm)
            LK_ADDR, LK_SUB, LK_WRITE: begin
               if (s_q.bitcnt < BITS_PER_BYTE) begin
                  s_d.shreg = {s_q.shreg[6:0], s_q.sda_s};
                  s_d.bitcnt = s_q.bitcnt + 4'h1;
               end
            end
            LK_READ_ACK: begin
               if (s_q.sda_s) begin
                  s_d.fsm = LK_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (s_q.fsm)
            LK_ADDR: begin
               if (s_q.bitcnt == BITS_PER_BYTE) begin
                  if (s_q.shreg[7:1] == DEV_ADDR) begin
                     s_d.fsm = LK_ADDR_ACK;
                     s_d.rw = s_q.shreg[0];
                     s_d.drive = 1'b1;
                  end else begin
                     s_d.fsm = LK_IDLE;
                  end
               end
            end
            LK_ADDR_ACK, LK_READ_ACK: begin
               if (s_q.fsm == LK_ADDR_ACK && !s_q.rw) begin
                  s_d.fsm = LK_SUB;
                  s_d.bitcnt = 4'h0;
                  s_d.drive = 1'b0;
               end else begin
                  rd = rd_byte(s_q.subaddr, s_q.gamma, avg_brightness, s_q.clkctrl); // RULE8
                  s_d.shreg = rd;
                  s_d.drive = !rd[7];
                  s_d.bitcnt = 4'h1;
                  s_d.fsm = LK_READ;
               end
            end
            LK_SUB: begin
               if (s_q.bitcnt == BITS_PER_BYTE) begin
                  s_d.subaddr = s_q.shreg[5:0];
                  s_d.drive = 1'b1;
                  s_d.fsm = LK_SUB_ACK;
               end
            end
            LK_SUB_ACK, LK_WRITE_ACK: begin
               s_d.drive = 1'b0;
               s_d.bitcnt = 4'h0;
               s_d.fsm = LK_WRITE;
            end
            LK_WRITE: begin
               if (s_q.bitcnt == BITS_PER_BYTE) begin
                  // Reserved clock bits are stored as written and read back unchanged.
                  if (gamma_hit) begin
                     s_d.gamma[gidx] = s_q.shreg; // RULE1
                  end else if (s_q.subaddr == SUB_CLOCK_CTRL) begin
                     s_d.clkctrl = s_q.shreg; // RULE11
                  end
                  s_d.subaddr = s_q.subaddr + 6'h01;
                  s_d.drive = 1'b1;
                  s_d.fsm = LK_WRITE_ACK;
               end
            end
            LK_READ: begin
               if (s_q.bitcnt == BITS_PER_BYTE) begin
                  s_d.drive = 1'b0;
                  s_d.subaddr = s_q.subaddr + 6'h01;
                  s_d.fsm = LK_READ_ACK;
               end else begin
                  s_d.drive = !s_q.shreg[3'(4'h7 - s_q.bitcnt)];
                  s_d.bitcnt = s_q.bitcnt + 4'h1;
               end
            end
            default: begin
               s_d.fsm = s_q.fsm;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
         s_q.scl_meta <= 1'b1;
         s_q.scl_s <= 1'b1;
         s_q.scl_prev <= 1'b1;
         s_q.sda_meta <= 1'b1;
         s_q.sda_s <= 1'b1;
         s_q.sda_prev <= 1'b1;
         s_q.fsm <= LK_IDLE;
         s_q.gamma <= {GAMMA_RESET, GAMMA_RESET}; // RULE15
         s_q.clkctrl <= CLOCK_CTRL_RESET; // RULE14
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // The line is open drain: only a low is ever driven.
   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = !s_q.drive;
   assign o_chroma = s_q.chroma;
   // The gate is a plain AND; the enable changes on register writes and on the PLL disable and oversampling bits,
   // so a runt pulse at those moments is accepted in exchange for no extra domain.
   assign o_pll_clock_output_pin = i_pll_clk && s_q.pll_clock_output_pin_en; // RULE11

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   chk_chroma_pass: assert property ( // RULE2
      i_ce |=> o_chroma == $past(i_chroma))
      else $error("Chroma was not passed through unchanged.");
   chk_gamma_write: assert property ( // RULE1
      i_ce && wr_fire && gamma_hit |=> s_q.gamma[$past(gidx)] == $past(s_q.shreg))
      else $error("Gamma register write was lost.");
   chk_ro_bright: assert property ( // RULE8
      i_ce && wr_fire && s_q.subaddr == SUB_BRIGHTNESS
      |=> s_q.gamma == $past(s_q.gamma) && s_q.clkctrl == $past(s_q.clkctrl))
      else $error("Write to the brightness readback changed a register.");
   chk_clk_block: assert property ( // RULE12
      i_ce && (i_pll_disable_bit || !i_oversampling_enable_bit) |=> !o_pll_clock_output_pin)
      else $error("Clock pin driven without PLL and oversampling.");
   chk_clk_drive: assert property ( // RULE11
      i_ce && s_q.clkctrl[CLK_PIN_DRIVE_BIT] && !i_pll_disable_bit && i_oversampling_enable_bit
      |=> o_pll_clock_output_pin == i_pll_clk)
      else $error("Clock pin not following the PLL clock.");
endmodule

// ===== video_source_model.sv
// Upstream video source model: random luma fields with active windows and a vsync pulse.
`timescale 1ns/1ps
module video_source_model (
   input wire logic i_clk,
   input wire logic i_go,
   output logic o_valid,
   output logic o_active,
   output logic o_vsync_n,
   output logic [7:0] o_luma,
   output logic [7:0] o_chroma
);
   int n = 0;
   // Data lines churn every cycle, so a stale sample can never pass for a fresh one.
   always @(posedge i_clk) begin
      #1;
      n = i_go ? n + 1 : 0;
      o_active = i_go && (n % 16 > 3);
      o_valid = i_go && n < 300 && ($urandom % 4 != 0);
      o_vsync_n = !(n > 300 && n < 306);
      o_luma = 8'($urandom);
      o_chroma = 8'($urandom);
   end
endmodule

// ===== test_luma_gamma_brightness_unit.sv
// Self-checking bench for the luma gamma, brightness and clock output unit.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module test_luma_gamma_brightness_unit;
   import luma_gamma_pkg::*;
   logic clk = 0, rst = 1, scl = 1, m_sda = 1, go = 0, pclk = 0;
   logic gam_en = 0, sel_b = 0, pll_dis = 0, os_en = 0;
   logic sda, sda_oe_n, sda_out, vld, act, vs_n, o_vld, o_pin, vs_q = 1;
   logic [7:0] luma, chroma, o_luma, o_chroma;
   int failures = 0, compares = 0, cycles = 0;
   int crv[14], e_luma = 0, e_chroma = 0, e_vld = 0, bsum = 0, bcnt = 0, e_avg = 0;
   always #10 clk = ~clk;
   always #9.259 pclk = ~pclk;
   assign sda = m_sda & (sda_oe_n | sda_out);
   luma_gamma_brightness_unit #(.DEV_ADDR(7'h2c), .CNT_W(20)) DUT (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_pix_valid(vld),
      .i_active_video(act), .i_vsync_n(vs_n), .i_luma(luma), .i_chroma(chroma),
      .i_gamma_enable(gam_en), .i_curve_b_select(sel_b), .i_pll_disable_bit(pll_dis),
      .i_oversampling_enable_bit(os_en), .i_pll_clk(pclk), .o_pix_valid(o_vld),
      .o_luma(o_luma), .o_chroma(o_chroma), .o_pll_clock_output_pin(o_pin));
   video_source_model src (.i_clk(clk), .i_go(go), .o_valid(vld), .o_active(act),
      .o_vsync_n(vs_n), .o_luma(luma), .o_chroma(chroma));
   // -----------------------------------------------------------------
   // Reference model
   // -----------------------------------------------------------------
   function automatic int gmap(int x, int b);
      int xa, ya, yb, s;
      if (!gam_en || x < 16 || x > 240) return x;
      s = (x < 32 || x >= 224) ? 4 : 5;
      xa = x < 32 ? 16 : (x >= 224 ? 224 : x / 32 * 32);
      ya = xa == 16 ? 16 : crv[b * 7 + xa / 32 - 1];
      yb = xa == 224 ? 240 : crv[b * 7 + (xa + (1 << s)) / 32 - 1];
      return ya + ((yb - ya) * (x - xa) >>> s);
   endfunction
   always @(posedge clk) begin
      if (rst) begin
         e_vld = 0;
         bsum = 0;
         bcnt = 0;
      end else begin
         if (e_vld) begin
            `CHK(o_luma, 8'(e_luma))
            `CHK(o_chroma, 8'(e_chroma))
         end
         `CHK(o_vld, 1'(e_vld))
         if (vs_q && !vs_n) begin
            e_avg = bcnt ? bsum / bcnt : 0;
            bsum = 0;
            bcnt = 0;
         end else if (vld && act) begin
            bsum += luma;
            bcnt++;
         end
      end
      vs_q = vs_n;
      e_vld = vld;
      e_luma = gmap(luma, sel_b);
      e_chroma = chroma;
      // The ceiling is about twice the expected run length.
      cycles++;
      if (cycles == 40000) begin
         failures++;
         complete_run();
      end
   end
   // -----------------------------------------------------------------
   // Two-wire host tasks
   // -----------------------------------------------------------------
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic bit_io(input logic b, output logic r);
      scl = 0;
      tick(4);
      m_sda = b;
      tick(4);
      scl = 1;
      tick(8);
      r = sda;
   endtask
   task automatic edge_cond(input logic first);
      scl = 0;
      tick(4);
      m_sda = first;
      tick(4);
      scl = 1;
      tick(8);
      m_sda = !first;
      tick(8);
   endtask
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      // The host lets the line go in the acknowledge slot of a byte it sends.
      bit_io(d == 8'hff ? last : 1'b1, a);
      if (d != 8'hff) `CHK(a, 1'b0)
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d[$]);
      logic [7:0] q;
      edge_cond(1'b1);
      xfer(8'h58, 1'b0, q);
      xfer({2'b00, a}, 1'b0, q);
      foreach (d[i]) xfer(d[i], 1'b0, q);
      edge_cond(1'b0);
   endtask
   task automatic rd(input logic [5:0] a, input int n, output logic [7:0] q[$]);
      logic [7:0] v;
      q = {};
      edge_cond(1'b1);
      xfer(8'h58, 1'b0, v);
      xfer({2'b00, a}, 1'b0, v);
      edge_cond(1'b1);
      xfer(8'h59, 1'b0, v);
      for (int i = 0; i < n; i++) begin
         xfer(8'hff, i == n - 1, v);
         q.push_back(v);
      end
      edge_cond(1'b0);
   endtask
   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      logic [7:0] q[$];
      logic [7:0] pts[$];
      void'($urandom(32'h29d4e303));
      for (int i = 0; i < 14; i++) crv[i] = 32 * (i % 7 + 1);
      repeat (8) @(posedge clk);
      #1 rst = 0;
      tick(4);
      rd(SUB_GAMMA_FIRST, 14, q);
      foreach (q[i]) `CHK(q[i], 8'(crv[i]))
      wr(SUB_BRIGHTNESS, {8'h55});
      rd(SUB_BRIGHTNESS, 2, q);
      `CHK(q[0], BRIGHTNESS_RESET)
      `CHK(q[1], CLOCK_CTRL_RESET)
      rd(6'h3f, 1, q);
      `CHK(q[0], READ_UNMAPPED)
      $display("test registers done");
      for (int i = 0; i < 14; i++) begin
         crv[i] = 16 + $urandom % 225;
         pts.push_back(8'(crv[i]));
      end
      wr(SUB_GAMMA_FIRST, pts);
      rd(SUB_GAMMA_FIRST, 14, q);
      foreach (q[i]) `CHK(q[i], 8'(crv[i]))
      for (int m = 0; m < 3; m++) begin
         gam_en = m < 2;
         sel_b = m == 1;
         go = 1;
         tick(310);
         go = 0;
         tick(12);
         rd(SUB_BRIGHTNESS, 1, q);
         `CHK(q[0], 8'(e_avg))
         $display("test field %0d done", m);
      end
      // Only one of the five settings may let the PLL clock reach the pin.
      for (int k = 0; k < 5; k++) begin
         {pll_dis, os_en} = k == 4 ? 2'b01 : 2'(k);
         wr(SUB_CLOCK_CTRL, {k < 4 ? 8'h72 : 8'h70});
         rd(SUB_CLOCK_CTRL, 1, q);
         `CHK(q[0], k < 4 ? 8'h72 : 8'h70)
         repeat (6) begin
            #7;
            `CHK(o_pin, pclk & (k == 1))
         end
      end
      $display("test clock output done");
      complete_run();
   end
endmodule
